//--- logic/su_params.svh
`ifndef SU_PARAMS_SVH
`define SU_PARAMS_SVH
// Character width in synchronous mode
`define SU_SYNC_BITS      8
// Data width of a character in asynchronous mode (8 data bits)
`define SU_DATA_BITS      8
// Default baud divider (system clocks per half serial clock period)
`define SU_BAUD_HALF_DEF  16'h0004
// Oversampling ratio in asynchronous mode
`define SU_OVERSAMPLE     16
// Depth of the receive FIFO
`define SU_FIFO_DEPTH     4
// Reset value of the transmit-buffer-empty flag
`define SU_TDE_RESET      1'b1
// Reset value of the transmit-end flag
`define SU_TX_END_FLAG_RESET     1'b1
// Mode select codes
`define SU_MODE_ASYNC     1'b0
`define SU_MODE_SYNC      1'b1
`endif

//--- logic/su_pkg.sv
package su_pkg;
  // Transmit sequencer states
  typedef enum logic [1:0] {
    SU_TX_IDLE  = 2'b00,
    SU_TX_SHIFT = 2'b01,
    SU_TX_STOP  = 2'b10
  } su_tx_state_e;
  // Receive sequencer states
  typedef enum logic [1:0] {
    SU_RX_IDLE  = 2'b00,
    SU_RX_SHIFT = 2'b01,
    SU_RX_STOP  = 2'b10
  } su_rx_state_e;
  // Byte type
  typedef logic [7:0] su_byte_t;
endpackage : su_pkg

//--- logic/su_fifo.sv
`timescale 1ns/1ps
// ==========================================
// Small synchronous FIFO
module su_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input  wire logic             clock_i,
  input  wire logic             sys_rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ptr_ff;
  logic [AW-1:0]    rd_ptr_ff;
  logic [AW:0]      count_ff;
  logic             do_wr;
  logic             do_rd;

  // Handshake terms
  assign in_ready_o  = (count_ff != (AW+1)'(DEPTH));
  assign out_valid_o = (count_ff != '0);
  assign do_wr       = in_valid_i & in_ready_o;
  assign do_rd       = out_valid_o & out_ready_i;
  assign out_data_o  = mem_ff[rd_ptr_ff];

  // Storage
  always_ff @(posedge clock_i) begin
    if (do_wr) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_ff <= count_ff + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule : su_fifo

//--- logic/su_edge.sv
`timescale 1ns/1ps
// ==========================================
// Edge detector for the serial clock level
module su_edge (
  input  wire logic clock_i,
  input  wire logic sys_rst_i,
  input  wire logic level_i,
  output logic      rise_o,
  output logic      fall_o
);
  logic prev_ff;

  // Previous level, idles high
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prev_ff <= 1'b1;
    end else begin
      prev_ff <= level_i;
    end
  end

  assign rise_o = level_i & ~prev_ff;
  assign fall_o = ~level_i & prev_ff;
endmodule : su_edge

//--- logic/serial_unit.sv
`timescale 1ns/1ps
`include "su_params.svh"
module serial_unit
  import su_pkg::*;
#(
  parameter logic [15:0] BAUD_HALF = `SU_BAUD_HALF_DEF,
  parameter int          DEPTH     = `SU_FIFO_DEPTH
) (
  input  wire logic            clock_i,
  input  wire logic            sys_rst_i,
  input  wire logic            sync_mode_i,
  input  wire logic            clock_source_select_hi_i,
  input  wire logic            clock_source_select_lo_i,
  input  wire logic            multiproc_mode_i,
  input  wire logic            parity_enable_i,
  input  wire logic            parity_odd_i,
  input  wire logic            mp_filter_i,
  input  wire logic            tx_enable_i,
  input  wire logic            rx_enable_i,
  input  wire logic            tx_empty_irq_enable_i,
  input  wire logic            rx_irq_enable_i,
  input  wire logic            tx_done_irq_enable_i,
  input  wire logic            tx_write_i,
  input  wire su_pkg::su_byte_t tx_data_i,
  input  wire logic            multiproc_bit_i,
  input  wire logic            rx_read_i,
  input  wire logic            clear_errors_i,
  input  wire logic            serial_clk_in_i,
  input  wire logic            rxd_i,
  output logic                 txd_o,
  output logic                 serial_clk_o,
  output logic                 serial_clk_oe_o,
  output logic                 tx_buffer_empty_flag_o,
  output logic                 tx_end_flag_o,
  output logic                 rx_full_flag_o,
  output su_pkg::su_byte_t     rx_holding_reg_o,
  output logic                 rx_multiproc_bit_o,
  output logic                 overrun_flag_o,
  output logic                 framing_error_flag_o,
  output logic                 parity_error_flag_o,
  output logic                 rx_error_irq_o,
  output logic                 rx_full_irq_o,
  output logic                 tx_empty_irq_o,
  output logic                 tx_done_irq_o,
  output logic [1:0]           irq_top_o
);
  import su_pkg::*;

  // ==========================================
  // Declarations
  su_tx_state_e tx_st_ff;
  su_rx_state_e rx_st_ff;
  su_byte_t     tx_holding_reg_ff;
  logic         tx_mp_bit_ff;
  logic [9:0]   tx_shift_reg_ff;
  logic [3:0]   tx_cnt_ff;
  logic         tde_ff;
  logic         tx_end_flag_ff;
  logic         txd_ff;
  logic [8:0]   rx_shift_reg_ff;
  logic [3:0]   rx_cnt_ff;
  logic         rx_par_ff;
  logic         ovr_ff;
  logic         frm_err_ff;
  logic         per_ff;
  logic         skip_ff;
  logic [15:0]  baud_ff;
  logic         sclk_ff;
  logic [3:0]   os_cnt_ff;
  logic         int_clk;
  logic         any_err;
  logic         sync_rise;
  logic         sync_fall;
  logic         os_tick;
  logic         bit_tick;
  logic         sample_tick;
  logic         tx_load;
  logic         rx_done;
  logic         rx_mp_bit;
  logic         rx_fe;
  logic         rx_pe;
  logic         rx_keep;
  logic         fifo_in_valid;
  logic         fifo_in_ready;
  logic         fifo_out_valid;
  logic         fifo_out_ready;
  logic [8:0]   fifo_out_data;
  logic         rx_run;
  logic         tx_run;
  logic         clk_level;
  logic         full_ff;
  su_byte_t     rdh_ff;
  logic         rmpb_ff;
  logic         tx_busy;

  // ==========================================
  // Clock selection
  // Internal clock unless the external source is picked
  assign int_clk = ~clock_source_select_hi_i;
  assign any_err = ovr_ff | frm_err_ff | per_ff;
  assign tx_busy = (tx_st_ff != SU_TX_IDLE);
  // Sync activity gating by error flags
  assign tx_run  = tx_enable_i & ~(sync_mode_i & any_err);
  assign rx_run  = rx_enable_i & ~(sync_mode_i & any_err);

  // Baud divider, toggles the internal serial clock
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      baud_ff <= 16'h0000;
      sclk_ff <= 1'b1;
    end else if (baud_ff == BAUD_HALF - 16'h0001) begin
      baud_ff <= 16'h0000;
      if (!sync_mode_i) begin
        sclk_ff <= ~sclk_ff;
      end else if (sclk_ff && ((tx_busy && tx_run) || rx_run)) begin
        sclk_ff <= 1'b0; // Falling edge starts a bit
      end else if (!sclk_ff) begin
        sclk_ff <= 1'b1;
      end
    end else begin
      baud_ff <= baud_ff + 16'h0001;
    end
  end

  // Serial clock level seen by the shifters
  assign clk_level = int_clk ? sclk_ff : serial_clk_in_i;

  su_edge u_edge (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .level_i   (clk_level),
    .rise_o    (sync_rise),
    .fall_o    (sync_fall)
  );

  // Pin stays high when no pulses are due
  assign serial_clk_o    = sclk_ff;
  assign serial_clk_oe_o = int_clk & clock_source_select_lo_i | (int_clk & sync_mode_i);

  // Oversampling tick for asynchronous mode
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      os_cnt_ff <= 4'h0;
    end else if (sync_rise && !sync_mode_i) begin
      os_cnt_ff <= os_cnt_ff + 4'h1;
    end
  end
  assign os_tick     = sync_rise & ~sync_mode_i;
  // One bit per sixteen samples in async, one per falling edge in sync
  assign bit_tick    = sync_mode_i ? sync_fall : (os_tick && os_cnt_ff == 4'hF);
  assign sample_tick = sync_mode_i ? sync_rise : (os_tick && os_cnt_ff == 4'h7);

  // ==========================================
  // Transmitter
  assign tx_load = tx_run && !tde_ff &&
                   ((tx_st_ff == SU_TX_IDLE) ||
                    ((bit_tick || sync_mode_i) && tx_st_ff != SU_TX_IDLE && tx_cnt_ff == 4'h0));

  // Holding register and empty flag
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tde_ff            <= `SU_TDE_RESET;
      tx_holding_reg_ff <= 8'h00;
      tx_mp_bit_ff      <= 1'b0;
    end else if (!tx_enable_i) begin
      tde_ff <= 1'b1;
    end else if (tx_write_i) begin
      tx_holding_reg_ff <= tx_data_i;
      tx_mp_bit_ff      <= multiproc_bit_i;
      tde_ff            <= 1'b0;
    end else if (tx_load) begin
      tde_ff <= 1'b1;
    end
  end

  // Shifter: sync sends 8 data bits, async frames start/data/stop, extra bit only with multiprocessor or parity
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_st_ff        <= SU_TX_IDLE;
      tx_shift_reg_ff <= 10'h3FF;
      tx_cnt_ff       <= 4'h0;
      tx_end_flag_ff         <= `SU_TX_END_FLAG_RESET;
      txd_ff          <= 1'b1;
    end else if (!tx_enable_i) begin
      tx_st_ff        <= SU_TX_IDLE;
      tx_shift_reg_ff <= 10'h3FF;
      tx_cnt_ff       <= 4'h0;
      tx_end_flag_ff         <= 1'b1;
    end else if (tx_load) begin
      tx_end_flag_ff  <= 1'b0;
      tx_st_ff <= SU_TX_SHIFT;
      if (sync_mode_i) begin
        tx_shift_reg_ff <= {2'b11, tx_holding_reg_ff};
        tx_cnt_ff       <= 4'h8;
      end else if (multiproc_mode_i) begin
        tx_shift_reg_ff <= {1'b1, tx_mp_bit_ff, tx_holding_reg_ff};
        tx_cnt_ff       <= 4'hB;
        txd_ff          <= 1'b0;
      end else if (parity_enable_i) begin
        tx_shift_reg_ff <= {1'b1, ^tx_holding_reg_ff ^ parity_odd_i, tx_holding_reg_ff};
        tx_cnt_ff       <= 4'hB;
        txd_ff          <= 1'b0;
      end else begin
        tx_shift_reg_ff <= {2'b11, tx_holding_reg_ff};
        tx_cnt_ff       <= 4'hA;
        txd_ff          <= 1'b0;
      end
    end else if ((bit_tick || (sync_mode_i && tx_cnt_ff == 4'h0)) && tx_st_ff == SU_TX_SHIFT) begin
      if (tx_cnt_ff == 4'h0) begin
        tx_st_ff <= SU_TX_IDLE;
        tx_end_flag_ff  <= 1'b1;
      end else begin
        // LSB first; final bit level persists
        if (sync_mode_i || tx_cnt_ff != 4'hB) begin
          txd_ff <= tx_shift_reg_ff[0];
          tx_shift_reg_ff <= {1'b1, tx_shift_reg_ff[9:1]};
        end
        tx_cnt_ff <= tx_cnt_ff - 4'h1;
      end
    end
  end
  assign txd_o                  = txd_ff;
  assign tx_buffer_empty_flag_o = tde_ff;
  assign tx_end_flag_o          = tx_end_flag_ff;

  // ==========================================
  // Receiver
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      rx_st_ff        <= SU_RX_IDLE;
      rx_shift_reg_ff <= 9'h000;
      rx_cnt_ff       <= 4'h0;
      rx_par_ff       <= 1'b0;
    end else if (!rx_run) begin
      rx_st_ff  <= SU_RX_IDLE;
      rx_cnt_ff <= 4'h0;
    end else if (sample_tick) begin
      unique case (rx_st_ff)
        SU_RX_IDLE: begin
          if (sync_mode_i) begin
            rx_shift_reg_ff <= {rxd_i, rx_shift_reg_ff[8:1]};
            rx_cnt_ff <= 4'h7;
            rx_st_ff  <= SU_RX_SHIFT;
          end else if (!rxd_i) begin
            rx_cnt_ff <= (multiproc_mode_i || parity_enable_i) ? 4'h9 : 4'h8;
            rx_st_ff  <= SU_RX_SHIFT;
          end
        end
        SU_RX_SHIFT: begin
          rx_shift_reg_ff <= {rxd_i, rx_shift_reg_ff[8:1]};
          rx_cnt_ff       <= rx_cnt_ff - 4'h1;
          if (rx_cnt_ff == 4'h1) begin
            rx_st_ff <= sync_mode_i ? SU_RX_IDLE : SU_RX_STOP;
          end
        end
        SU_RX_STOP: begin
          rx_par_ff <= rxd_i;
          rx_st_ff  <= SU_RX_IDLE;
        end
        default: rx_st_ff <= SU_RX_IDLE;
      endcase
    end
  end

  // Frame completion and decode
  assign rx_done = rx_run && sample_tick &&
                   ((sync_mode_i && rx_st_ff == SU_RX_SHIFT && rx_cnt_ff == 4'h1) ||
                    (!sync_mode_i && rx_st_ff == SU_RX_STOP));
  assign rx_mp_bit = rx_shift_reg_ff[8];
  assign rx_fe   = !sync_mode_i && !rxd_i;
  assign rx_pe   = !sync_mode_i && !multiproc_mode_i && parity_enable_i &&
                   (^rx_shift_reg_ff ^ parity_odd_i);
  // Filter data frames while waiting for an ID
  assign rx_keep = !(multiproc_mode_i && !sync_mode_i && skip_ff && !rx_mp_bit);

  // Completed characters queue here; sync byte uses freshly shifted bit
  assign fifo_in_valid = rx_done && rx_keep;
  su_fifo #(.WIDTH(9), .DEPTH(DEPTH)) u_fifo (
    .clock_i     (clock_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (sync_mode_i ? {1'b0, rxd_i, rx_shift_reg_ff[8:2]} :
                  (multiproc_mode_i || parity_enable_i) ? {rx_mp_bit, rx_shift_reg_ff[7:0]} :
                  {1'b0, rx_shift_reg_ff[8:1]}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fifo_out_ready),
    .out_data_o  (fifo_out_data)
  );
  // Holding register drains the queue only when empty
  assign fifo_out_ready = !full_ff && !ovr_ff;

  // Skip-state tracking for multiprocessor receive
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      skip_ff <= 1'b1;
    end else if (mp_filter_i) begin
      skip_ff <= 1'b1;
    end else if (rx_done && rx_mp_bit) begin
      skip_ff <= 1'b0;
    end
  end

  // Holding register, full flag, error flags; sets win over clears
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      full_ff <= 1'b0;
      rdh_ff  <= 8'h00;
      rmpb_ff <= 1'b0;
      ovr_ff  <= 1'b0;
      frm_err_ff <= 1'b0;
      per_ff  <= 1'b0;
    end else begin
      if (fifo_out_valid && fifo_out_ready) begin
        rdh_ff  <= fifo_out_data[7:0];
        rmpb_ff <= fifo_out_data[8];
        full_ff <= !(frm_err_ff || per_ff);
      end else if (rx_read_i) begin
        full_ff <= 1'b0;
      end
      ovr_ff <= (fifo_in_valid && !fifo_in_ready) | (ovr_ff & ~clear_errors_i);
      frm_err_ff <= (fifo_in_valid && rx_fe) | (frm_err_ff & ~clear_errors_i);
      per_ff <= (fifo_in_valid && rx_pe) | (per_ff & ~clear_errors_i);
    end
  end
  assign rx_full_flag_o       = full_ff;
  assign rx_holding_reg_o     = rdh_ff;
  assign rx_multiproc_bit_o   = rmpb_ff;
  assign overrun_flag_o       = ovr_ff;
  assign framing_error_flag_o = frm_err_ff;
  assign parity_error_flag_o  = per_ff;

  // ==========================================
  // Interrupt requests and priority
  assign rx_error_irq_o = rx_irq_enable_i & any_err;
  assign rx_full_irq_o  = rx_irq_enable_i & full_ff;
  assign tx_empty_irq_o = tx_empty_irq_enable_i & tde_ff & tx_enable_i;
  assign tx_done_irq_o  = tx_done_irq_enable_i & tx_end_flag_ff & tx_enable_i;
  // Highest pending: 0 error, 1 full, 2 empty, 3 end
  always_comb begin
    if (rx_error_irq_o) begin
      irq_top_o = 2'h0;
    end else if (rx_full_irq_o) begin
      irq_top_o = 2'h1;
    end else if (tx_empty_irq_o) begin
      irq_top_o = 2'h2;
    end else begin
      irq_top_o = 2'h3;
    end
  end
endmodule : serial_unit

//--- tb/su_asserts.sv
`timescale 1ns/1ps
// ==========================================
// Port checker for the serial unit
module su_sync_chk
  import su_pkg::*;
#(
  parameter int HALF = 4
) (
  input wire logic             clock_i,
  input wire logic             sys_rst_i,
  input wire logic             sync_mode_i,
  input wire logic             tx_enable_i,
  input wire logic             rx_enable_i,
  input wire logic             tx_empty_irq_enable_i,
  input wire logic             rx_irq_enable_i,
  input wire logic             tx_done_irq_enable_i,
  input wire logic             tx_write_i,
  input wire logic             rx_read_i,
  input wire logic             clear_errors_i,
  input wire logic             txd_o,
  input wire logic             serial_clk_o,
  input wire logic             tx_buffer_empty_flag_o,
  input wire logic             tx_end_flag_o,
  input wire logic             rx_full_flag_o,
  input wire su_pkg::su_byte_t rx_holding_reg_o,
  input wire logic             overrun_flag_o,
  input wire logic             framing_error_flag_o,
  input wire logic             parity_error_flag_o,
  input wire logic             rx_error_irq_o,
  input wire logic             rx_full_irq_o,
  input wire logic             tx_empty_irq_o,
  input wire logic             tx_done_irq_o,
  input wire logic [1:0]       irq_top_o
);
  logic       errs;
  logic [7:0] idle_cnt_ff;
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  // Any receive error flag
  assign errs = overrun_flag_o | framing_error_flag_o | parity_error_flag_o;
  // Cycles spent with transmit ended and receiver off
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      idle_cnt_ff <= 8'h00;
    end else if (!tx_end_flag_o || rx_enable_i) begin
      idle_cnt_ff <= 8'h00;
    end else if (idle_cnt_ff != 8'hFF) begin
      idle_cnt_ff <= idle_cnt_ff + 8'h01;
    end
  end
  // ==========================================
  // Assertions
  write_taken_a: assert property (tx_write_i && tx_enable_i |=> !tx_buffer_empty_flag_o)
    else $error("write did not clear empty flag");
  end_cause_a: assert property ($rose(tx_end_flag_o) |-> tx_buffer_empty_flag_o)
    else $error("end flag set with data pending");
  clk_idle_a: assert property (idle_cnt_ff >= 3 * HALF |-> serial_clk_o)
    else $error("serial clock low after transmit end");
  err_halt_a: assert property (sync_mode_i && errs && $past(errs) && !clear_errors_i && serial_clk_o
    |=> serial_clk_o)
    else $error("serial clock ran with error flag set");
  bit_stable_a: assert property (tx_enable_i && $past(tx_enable_i) && $rose(serial_clk_o) |-> $stable(txd_o))
    else $error("data changed on rising clock");
  hold_keep_a: assert property (rx_full_flag_o && !rx_read_i |=> $stable(rx_holding_reg_o))
    else $error("holding register overwritten while full");
  ovr_keep_a: assert property ($rose(overrun_flag_o) |-> rx_full_flag_o && $stable(rx_holding_reg_o))
    else $error("overrun replaced held data");
  irq_gate_a: assert property ({rx_error_irq_o, rx_full_irq_o, tx_empty_irq_o, tx_done_irq_o} ==
    {errs && rx_irq_enable_i, rx_full_flag_o && rx_irq_enable_i,
     tx_buffer_empty_flag_o && tx_empty_irq_enable_i && tx_enable_i,
     tx_end_flag_o && tx_done_irq_enable_i && tx_enable_i})
    else $error("request not equal to flag and enable");
  prio_a: assert property (irq_top_o == (rx_error_irq_o ? 2'h0 : rx_full_irq_o ? 2'h1 : tx_empty_irq_o ? 2'h2 : 2'h3))
    else $error("wrong top request");
  // Main scenarios
  end_c: cover property ($rose(tx_end_flag_o));
  full_c: cover property ($rose(rx_full_flag_o));
  ovr_c: cover property ($rose(overrun_flag_o));
endmodule : su_sync_chk

bind serial_unit su_sync_chk #(.HALF(BAUD_HALF)) u_chk (
  .clock_i, .sys_rst_i, .sync_mode_i, .tx_enable_i, .rx_enable_i, .tx_empty_irq_enable_i, .rx_irq_enable_i,
  .tx_done_irq_enable_i, .tx_write_i, .rx_read_i, .clear_errors_i, .txd_o, .serial_clk_o,
  .tx_buffer_empty_flag_o, .tx_end_flag_o, .rx_full_flag_o, .rx_holding_reg_o, .overrun_flag_o,
  .framing_error_flag_o, .parity_error_flag_o, .rx_error_irq_o, .rx_full_irq_o, .tx_empty_irq_o,
  .tx_done_irq_o, .irq_top_o
);

//--- tb/su_peer.sv
`timescale 1ns/1ps
// ==========================================
// Far-side node: counting byte stream out, capture of the data line in
module su_peer #(
  parameter logic [7:0] BASE = 8'hC3
) (
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire logic       sclk_i,
  input  wire logic       txd_i,
  output logic            rxd_o,
  output logic      [7:0] cap_o,
  output int              cap_cnt_o,
  output int              rise_cnt_o,
  output int              sent_cnt_o
);
  logic       sclk_ff;
  logic [7:0] sh_ff;
  logic [7:0] cur;
  logic [2:0] fidx_ff;
  logic [1:0] hold_ff;
  // Byte of the frame now on the line
  assign cur = BASE + sent_cnt_o[7:0];
  // Line clock edge handling
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sclk_ff    <= 1'b1;
      sh_ff      <= 8'h00;
      fidx_ff    <= 3'h0;
      hold_ff    <= 2'h0;
      rxd_o      <= 1'b1;
      cap_o      <= 8'h00;
      cap_cnt_o  <= 0;
      rise_cnt_o <= 0;
      sent_cnt_o <= 0;
    end else begin
      sclk_ff <= sclk_i;
      if (sclk_ff && !sclk_i) begin // Next bit on falling edge, LSB first
        rxd_o   <= cur[fidx_ff];
        fidx_ff <= fidx_ff + 3'h1;
        if (fidx_ff == 3'h7) begin
          sent_cnt_o <= sent_cnt_o + 1;
        end
      end else if (!sclk_ff && sclk_i) begin // Capture on rising edge
        sh_ff      <= {txd_i, sh_ff[7:1]};
        rise_cnt_o <= rise_cnt_o + 1;
        hold_ff    <= 2'h3;
        if (rise_cnt_o[2:0] == 3'h7) begin
          cap_o     <= {txd_i, sh_ff[7:1]};
          cap_cnt_o <= cap_cnt_o + 1;
        end
      end else if (hold_ff != 2'h0) begin
        hold_ff <= hold_ff - 2'h1;
        if (hold_ff == 2'h1 && fidx_ff == 3'h0) begin
          rxd_o <= ~rxd_o; // Frame over: no stale bit
        end
      end
    end
  end
endmodule : su_peer

//--- tb/serial_unit_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
`define WAITC(c, n) begin for (int k = 0; k < (n) && !(c); k++) tick(1); \
  if (!(c)) begin failures++; $display("[ERR] %0t wait ran out", $time); final_report(); end end
// ==========================================
// Testbench top for the serial unit
module serial_unit_tb_top;
  import su_pkg::*;
  localparam su_byte_t BASE  = 8'hC3;
  localparam int       DEPTH = 4;
  logic       clock_i, sys_rst_i, sync_mode_i, clock_source_select_hi_i, clock_source_select_lo_i;
  logic       multiproc_mode_i, parity_enable_i, parity_odd_i, mp_filter_i, tx_enable_i, rx_enable_i;
  logic       tx_empty_irq_enable_i, rx_irq_enable_i, tx_done_irq_enable_i, tx_write_i, multiproc_bit_i;
  logic       rx_read_i, clear_errors_i, serial_clk_in_i, rxd_i, txd_o, serial_clk_o, serial_clk_oe_o;
  logic       tx_buffer_empty_flag_o, tx_end_flag_o, rx_full_flag_o, rx_multiproc_bit_o, overrun_flag_o;
  logic       framing_error_flag_o, parity_error_flag_o, rx_error_irq_o, rx_full_irq_o, tx_empty_irq_o;
  logic       tx_done_irq_o;
  logic [1:0] irq_top_o;
  su_byte_t   tx_data_i, rx_holding_reg_o, cap;
  int         failures, n_checks, rise_cnt, cap_cnt, sent_cnt;
  // Design and far-side node
  serial_unit #(.BAUD_HALF(16'h0004), .DEPTH(DEPTH)) DUT (
    .clock_i, .sys_rst_i, .sync_mode_i, .clock_source_select_hi_i, .clock_source_select_lo_i,
    .multiproc_mode_i, .parity_enable_i, .parity_odd_i, .mp_filter_i, .tx_enable_i, .rx_enable_i,
    .tx_empty_irq_enable_i, .rx_irq_enable_i, .tx_done_irq_enable_i, .tx_write_i, .tx_data_i,
    .multiproc_bit_i, .rx_read_i, .clear_errors_i, .serial_clk_in_i, .rxd_i, .txd_o, .serial_clk_o,
    .serial_clk_oe_o, .tx_buffer_empty_flag_o, .tx_end_flag_o, .rx_full_flag_o, .rx_holding_reg_o,
    .rx_multiproc_bit_o, .overrun_flag_o, .framing_error_flag_o, .parity_error_flag_o,
    .rx_error_irq_o, .rx_full_irq_o, .tx_empty_irq_o, .tx_done_irq_o, .irq_top_o
  );
  su_peer #(.BASE(BASE)) u_peer (.clock_i, .sys_rst_i, .sclk_i(serial_clk_o), .txd_i(txd_o), .rxd_o(rxd_i),
    .cap_o(cap), .cap_cnt_o(cap_cnt), .rise_cnt_o(rise_cnt), .sent_cnt_o(sent_cnt));
  // 25 MHz clock
  initial clock_i = 1'b0;
  always #20 clock_i = ~clock_i;
  // ==========================================
  // Helpers
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clock_i);
      #1;
    end
  endtask : tick
  task automatic wr(input su_byte_t d);
    @(posedge clock_i);
    tx_data_i  <= d;
    tx_write_i <= 1'b1;
    @(posedge clock_i);
    tx_write_i <= 1'b0;
    #1;
  endtask : wr
  task automatic final_report();
    if (failures == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  // ==========================================
  // Scenarios
  task automatic t_tx_one();
    int r0 = rise_cnt;
    int c0 = cap_cnt;
    wr(8'h35);
    `WAITC(tx_buffer_empty_flag_o === 1'b1, 4)
    `CHK(tx_empty_irq_o, 1'b1)
    `CHK(serial_clk_oe_o, 1'b1)
    `WAITC(cap_cnt == c0 + 1, 120)
    tick(16);
    `CHK(cap, 8'h35)
    `CHK(rise_cnt - r0, 8)
    `CHK(txd_o, 1'b0)
    `CHK({serial_clk_o, tx_end_flag_o, tx_done_irq_o}, 3'h7)
    `CHK(irq_top_o, 2'h2)
  endtask : t_tx_one
  task automatic t_tx_b2b();
    int r0 = rise_cnt;
    int c0 = cap_cnt;
    @(posedge clock_i);
    {multiproc_mode_i, parity_enable_i, parity_odd_i, multiproc_bit_i, mp_filter_i} <= 5'h1F;
    wr(8'hCA);
    `WAITC(tx_buffer_empty_flag_o === 1'b1, 4)
    wr(8'h5C);
    `WAITC(cap_cnt == c0 + 1, 120)
    `CHK({cap, tx_end_flag_o}, 9'h194)
    `WAITC(cap_cnt == c0 + 2, 120)
    tick(16);
    `CHK(cap, 8'h5C)
    `CHK(rise_cnt - r0, 16)
    @(posedge clock_i);
    {multiproc_mode_i, parity_enable_i, parity_odd_i, multiproc_bit_i, mp_filter_i} <= 5'h00;
  endtask : t_tx_b2b
  task automatic t_rx_ovr();
    int f0 = sent_cnt;
    int r0 = rise_cnt;
    int c0;
    int j;
    @(posedge clock_i);
    rx_enable_i <= 1'b1;
    `WAITC(rise_cnt != r0, 24)
    `WAITC(rx_full_flag_o === 1'b1, 120)
    `CHK({rx_holding_reg_o, rx_full_irq_o}, {su_byte_t'(BASE + f0), 1'b1})
    `WAITC(overrun_flag_o === 1'b1, 700)
    tick(2);
    `CHK({rx_error_irq_o, irq_top_o}, 3'h4)
    `CHK(rx_holding_reg_o, su_byte_t'(BASE + f0))
    `CHK(rx_multiproc_bit_o, 1'b0)
    r0 = rise_cnt;
    tick(40);
    `CHK(rise_cnt - r0, 0)
    @(posedge clock_i);
    rx_enable_i <= 1'b0;
    tick(2);
    `CHK({overrun_flag_o, rx_full_flag_o}, 2'h3)
    c0 = cap_cnt;
    wr(8'h96);
    tick(40);
    `CHK(rise_cnt - r0, 0)
    @(posedge clock_i);
    clear_errors_i <= 1'b1;
    @(posedge clock_i);
    clear_errors_i <= 1'b0;
    `WAITC(cap_cnt == c0 + 1, 120)
    `CHK(cap, 8'h96)
    for (j = 0; j < 8 && rx_full_flag_o === 1'b1; j++) begin
      `CHK(rx_holding_reg_o, su_byte_t'(BASE + f0 + j))
      @(posedge clock_i);
      rx_read_i <= 1'b1;
      @(posedge clock_i);
      rx_read_i <= 1'b0;
      tick(4);
    end
    `CHK(j, DEPTH + 1)
  endtask : t_rx_ovr
  task automatic t_tx_abort();
    wr(8'hF0);
    tick(12);
    @(posedge clock_i);
    tx_enable_i <= 1'b0;
    tick(2);
    `CHK(tx_buffer_empty_flag_o, 1'b1)
    @(posedge clock_i);
    {tx_enable_i, rx_enable_i} <= 2'h3;
    `WAITC(rx_full_flag_o === 1'b1, 120)
  endtask : t_tx_abort
  // ==========================================
  // Main sequence
  initial begin
    {sync_mode_i, tx_empty_irq_enable_i, rx_irq_enable_i, tx_done_irq_enable_i, serial_clk_in_i} = 5'h1F;
    {clock_source_select_hi_i, clock_source_select_lo_i, multiproc_mode_i, parity_enable_i} = 4'h0;
    {parity_odd_i, mp_filter_i, tx_enable_i, rx_enable_i, tx_write_i, multiproc_bit_i} = 6'h00;
    {rx_read_i, clear_errors_i, tx_data_i} = 10'h000;
    failures = 0;
    n_checks = 0;
    sys_rst_i = 1'b1;
    repeat (16) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    tick(2);
    `CHK({txd_o, serial_clk_o, tx_buffer_empty_flag_o, tx_end_flag_o}, 4'hF)
    `CHK({rx_full_flag_o, overrun_flag_o, framing_error_flag_o, parity_error_flag_o}, 4'h0)
    @(posedge clock_i);
    tx_enable_i <= 1'b1;
    tick(4);
    t_tx_one();
    t_tx_b2b();
    t_rx_ovr();
    t_tx_abort();
    final_report();
  end
endmodule : serial_unit_tb_top
